// ==== core/uibg_pkg.sv ====
// shared constants and types for the uart interrupt enable and baud block
package uibg_pkg;

    // register byte addresses on the wishbone bus
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h04;
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h08;
    localparam logic [7:0] ADDR_SCRATCH = 8'h0C;
    localparam logic [7:0] ADDR_MODEM_CTRL = 8'h10;
    localparam logic [7:0] ADDR_SPEED_CFG = 8'h14;
    localparam logic [7:0] ADDR_PRESCALE_CFG = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;

    // field positions
    localparam int IRQ_EN_RX_READY = 0;
    localparam int IRQ_EN_TX_EMPTY = 1;
    localparam int IRQ_EN_LINE = 2;
    localparam int IRQ_EN_MODEM = 3;
    localparam int IRQ_EN_WIDTH = 4;
    localparam int MODEM_CTRL_IRQ_OUT = 3;
    localparam int SPEED_CFG_LO = 6;
    localparam int SPEED_CFG_HI = 7;
    localparam int STATUS_IRQ_OUT = 4;
    localparam int STATUS_HIGH_SPEED = 5;

    // values after reset
    localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;
    localparam logic [15:0] DIVISOR_RST = 16'h0000;
    localparam logic [7:0] SCRATCH_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // encodings
    localparam logic [1:0] SPEED_HIGH = 2'h3;
    localparam logic [1:0] PRESCALE_13 = 2'h0;
    localparam logic [1:0] PRESCALE_1P625 = 2'h1;
    localparam logic [1:0] PRESCALE_1 = 2'h2;
    localparam logic [3:0] IDENT_NONE = 4'h1;
    localparam logic [3:0] IDENT_LINE = 4'h6;
    localparam logic [3:0] IDENT_RX = 4'h4;
    localparam logic [3:0] IDENT_TIMEOUT = 4'hC;
    localparam logic [3:0] IDENT_TX = 4'h2;
    localparam logic [3:0] IDENT_MODEM = 4'h0;

    // clock rates, in MHz, and the fractional ratios built from them
    localparam int CORE_CLK_MHZ = 50;
    localparam int REF_CLK_MHZ = 24;
    localparam logic [5:0] REF_NUM = 6'(REF_CLK_MHZ);
    localparam logic [5:0] REF_DEN = 6'(CORE_CLK_MHZ);
    // 13 = 13/1, 1.625 = 13/8, 1.0 = 1/1 (denominator over numerator)
    localparam logic [5:0] PRE_NUM_13 = 6'h01;
    localparam logic [5:0] PRE_NUM_1P625 = 6'h08;
    localparam logic [5:0] PRE_DEN_13 = 6'h0D;
    localparam logic [5:0] PRE_ONE = 6'h01;

    typedef struct packed {
        logic modem_change;
        logic line_status;
        logic tx_empty;
        logic rx_ready;
        logic rx_timeout;
    } uibg_src_s;

    typedef struct packed {
        logic [5:0] num;
        logic [5:0] den;
    } uibg_ratio_s;

endpackage : uibg_pkg

// ==== core/uibg_top.sv ====
// uart interrupt enables, gating, identification and baud rate generator
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - interrupt enable bits seven to four read zero
// - bit three enables modem status change interrupt
// - bit two enables receive line status interrupt
// - bit one enables transmit holding empty interrupt
// - bit zero enables received data ready interrupt
// - all enables clear means no interrupt
// - two divisor bytes form sixteen bit divisor
// - divider output is sixteen times bit rate
// - high speed divides undivided 24 MHz directly
// - prescale selects 13, 1.625 or 1.0
// - scratch byte reads back written value
// - interrupt output needs modem control enable bit
// - report line, then rx, tx, modem
module uibg_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // interrupt sources from the rest of the uart, levels
    input wire uibg_pkg::uibg_src_s irq_src,
    // interrupt and identification towards the uart
    output logic uart_irq,
    output logic [3:0] irq_ident,
    // sixteen times bit rate tick for transmitter and receiver
    output logic tick16
);

    // fractional step: acc + num, wrap at den, report the wrap
    function automatic logic [6:0] frac_step(
        input logic [5:0] acc,
        input logic [5:0] num,
        input logic [5:0] den
    );
        logic [6:0] sum;
        sum = {1'b0, acc} + {1'b0, num};
        if (sum >= {1'b0, den}) begin
            frac_step = {1'b1, 6'(sum - {1'b0, den})};
        end else begin
            frac_step = {1'b0, sum[5:0]};
        end
    endfunction : frac_step

    // first hit in reporting order wins
    function automatic logic [3:0] ident_of(
        input logic [3:0] pend,
        input logic timeout
    );
        if (pend[uibg_pkg::IRQ_EN_LINE]) begin
            ident_of = uibg_pkg::IDENT_LINE;
        end else if (pend[uibg_pkg::IRQ_EN_RX_READY]) begin
            ident_of = timeout ? uibg_pkg::IDENT_TIMEOUT
                               : uibg_pkg::IDENT_RX;
        end else if (pend[uibg_pkg::IRQ_EN_TX_EMPTY]) begin
            ident_of = uibg_pkg::IDENT_TX;
        end else if (pend[uibg_pkg::IRQ_EN_MODEM]) begin
            ident_of = uibg_pkg::IDENT_MODEM;
        end else begin
            ident_of = uibg_pkg::IDENT_NONE;
        end
    endfunction : ident_of

    // registers
    logic [3:0] irq_enable_q;
    logic [7:0] baud_divisor_low_q;
    logic [7:0] baud_divisor_high_q;
    logic [7:0] scratch_q;
    logic [7:0] modem_control_reg_q;
    logic [7:0] speed_config_q;
    logic [7:0] prescale_config_q;

    // bus handshake
    logic access;
    logic wr_en;
    logic ack_q;
    logic [31:0] dat_r_q;
    logic [7:0] rd_byte;

    // interrupt path
    logic [3:0] pending;
    logic uart_irq_q;
    logic [3:0] irq_ident_q;

    // baud path
    logic high_speed;
    logic [15:0] divisor;
    uibg_pkg::uibg_ratio_s pre_ratio;
    logic [5:0] ref_acc_q;
    logic [5:0] pre_acc_q;
    logic [6:0] ref_next;
    logic [6:0] pre_next;
    logic ref_tick;
    logic pre_tick;
    logic [15:0] count_q;
    logic tick16_q;

    // a request is answered one cycle after it is seen; ack then drops
    // a write lands at the taking edge, the same edge that raises ack; the
    // master holds the request until ack, so nothing is lost
    assign access = wb_cyc & wb_stb & ~ack_q;
    assign wr_en = access & wb_we & wb_sel[0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    // write side, one block per register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_enable_q <= uibg_pkg::IRQ_ENABLE_RST;
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_IRQ_ENABLE) begin
            // upper nibble is not stored at all
            irq_enable_q <= wb_dat_w[3:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            baud_divisor_low_q <= uibg_pkg::DIVISOR_RST[7:0];
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_DIV_LOW) begin
            baud_divisor_low_q <= wb_dat_w[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            baud_divisor_high_q <= uibg_pkg::DIVISOR_RST[15:8];
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_DIV_HIGH) begin
            baud_divisor_high_q <= wb_dat_w[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scratch_q <= uibg_pkg::SCRATCH_RST;
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_SCRATCH) begin
            // stored only; nothing else looks at it
            scratch_q <= wb_dat_w[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modem_control_reg_q <= uibg_pkg::BYTE_RST;
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_MODEM_CTRL) begin
            modem_control_reg_q <= wb_dat_w[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            speed_config_q <= uibg_pkg::BYTE_RST;
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_SPEED_CFG) begin
            speed_config_q <= wb_dat_w[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescale_config_q <= uibg_pkg::BYTE_RST;
        end else if (wr_en && wb_adr == uibg_pkg::ADDR_PRESCALE_CFG) begin
            prescale_config_q <= wb_dat_w[7:0];
        end
    end

    // read side; unmapped addresses read zero and are still acked
    always_comb begin
        case (wb_adr)
            uibg_pkg::ADDR_IRQ_ENABLE: begin
                rd_byte = {4'h0, irq_enable_q};
            end
            uibg_pkg::ADDR_DIV_LOW: begin
                rd_byte = baud_divisor_low_q;
            end
            uibg_pkg::ADDR_DIV_HIGH: begin
                rd_byte = baud_divisor_high_q;
            end
            uibg_pkg::ADDR_SCRATCH: begin
                rd_byte = scratch_q;
            end
            uibg_pkg::ADDR_MODEM_CTRL: begin
                rd_byte = modem_control_reg_q;
            end
            uibg_pkg::ADDR_SPEED_CFG: begin
                rd_byte = speed_config_q;
            end
            uibg_pkg::ADDR_PRESCALE_CFG: begin
                rd_byte = prescale_config_q;
            end
            // status is read only; writes to it are acked and dropped
            uibg_pkg::ADDR_STATUS: begin
                rd_byte = {2'h0, high_speed, uart_irq_q, irq_ident_q};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dat_r_q <= 32'h0000_0000;
        end else if (access) begin
            dat_r_q <= wb_we ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    // interrupt gating: each source masked by its own enable
    always_comb begin
        pending[uibg_pkg::IRQ_EN_MODEM] =
            irq_src.modem_change & irq_enable_q[uibg_pkg::IRQ_EN_MODEM];
        pending[uibg_pkg::IRQ_EN_LINE] =
            irq_src.line_status & irq_enable_q[uibg_pkg::IRQ_EN_LINE];
        pending[uibg_pkg::IRQ_EN_TX_EMPTY] =
            irq_src.tx_empty & irq_enable_q[uibg_pkg::IRQ_EN_TX_EMPTY];
        pending[uibg_pkg::IRQ_EN_RX_READY] =
            irq_src.rx_ready & irq_enable_q[uibg_pkg::IRQ_EN_RX_READY];
    end

    // registered so the pin never glitches while sources settle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            uart_irq_q <= 1'b0;
        end else begin
            uart_irq_q <= modem_control_reg_q[uibg_pkg::MODEM_CTRL_IRQ_OUT]
                          & (|pending);
        end
    end

    // identification follows the enabled sources even with output off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_ident_q <= uibg_pkg::IDENT_NONE;
        end else begin
            irq_ident_q <= ident_of(pending, irq_src.rx_timeout);
        end
    end

    // baud configuration
    assign high_speed = speed_config_q[uibg_pkg::SPEED_CFG_HI:
                                       uibg_pkg::SPEED_CFG_LO]
                        == uibg_pkg::SPEED_HIGH;
    assign divisor = {baud_divisor_high_q, baud_divisor_low_q};

    always_comb begin
        // high speed bypasses the prescaler but keeps the same divisor
        if (high_speed) begin
            pre_ratio = '{num: uibg_pkg::PRE_ONE,
                          den: uibg_pkg::PRE_ONE};
        end else begin
            case (prescale_config_q[1:0])
                uibg_pkg::PRESCALE_1P625: begin
                    pre_ratio = '{num: uibg_pkg::PRE_NUM_1P625,
                                  den: uibg_pkg::PRE_DEN_13};
                end
                uibg_pkg::PRESCALE_1: begin
                    pre_ratio = '{num: uibg_pkg::PRE_ONE,
                                  den: uibg_pkg::PRE_ONE};
                end
                default: begin
                    pre_ratio = '{num: uibg_pkg::PRE_NUM_13,
                                  den: uibg_pkg::PRE_DEN_13};
                end
            endcase
        end
    end

    // 24 MHz enable out of 50 MHz; edges jitter by one core cycle
    assign ref_next = frac_step(ref_acc_q, uibg_pkg::REF_NUM,
                                uibg_pkg::REF_DEN);
    assign ref_tick = ref_next[6];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ref_acc_q <= 6'h00;
        end else begin
            ref_acc_q <= ref_next[5:0];
        end
    end

    // prescaler runs on the 24 MHz enable
    assign pre_next = frac_step(pre_acc_q, pre_ratio.num, pre_ratio.den);
    assign pre_tick = ref_tick & pre_next[6];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_acc_q <= 6'h00;
        end else if (ref_tick) begin
            // a ratio change can leave acc above den; this step then clears it to zero
            pre_acc_q <= (pre_next[5:0] >= pre_ratio.den) ? 6'h00
                                                           : pre_next[5:0];
        end
    end

    // a new divisor only loads at reload: software that needs it at
    // once writes zero first, which parks and empties the counter
    // divisor counter; a divisor of zero parks the generator
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_q <= 16'h0000;
        end else if (divisor == 16'h0000) begin
            count_q <= 16'h0000;
        end else if (pre_tick) begin
            if (count_q <= 16'h0001) begin
                count_q <= divisor;
            end else begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick16_q <= 1'b0;
        end else begin
            tick16_q <= pre_tick && divisor != 16'h0000
                        && count_q <= 16'h0001;
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_r_q;
    assign uart_irq = uart_irq_q;
    assign irq_ident = irq_ident_q;
    assign tick16 = tick16_q;

endmodule : uibg_top

// ==== dv/uart_irq_enable_baud_gen_test.sv ====
// self-checking bench for the uart irq enable and baud block
`timescale 1ns/1ps
module uart_irq_enable_baud_gen_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    uibg_pkg::uibg_src_s irq_src;
    logic uart_irq;
    logic [3:0] irq_ident;
    logic tick16;
    logic [31:0] q;
    int n_errors = 0;
    int checked = 0;
    always #10 core_clk = ~core_clk;
    uibg_top dut (.core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .irq_src(irq_src), .uart_irq(uart_irq), .irq_ident(irq_ident),
        .tick16(tick16));
    uibg_uart_stub peer (.core_clk(core_clk), .tick16(tick16),
        .irq_src(irq_src));
    task automatic results;
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask : chk
    task automatic chk_near(input string what, input int e, input int g);
        checked++;
        if (g > e + 2 || g < e - 2) begin
            n_errors++;
            $display("mismatch %s exp %0d got %0d", what, e, g);
        end
    endtask : chk_near
    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [7:0] d);
        int i;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_dat_w <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (wb_ack === 1'b1) break;
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (i == 20) begin
            n_errors++;
            results();
        end
    endtask : wb
    task automatic s_reset;
        for (int a = 0; a < 7; a++) begin
            wb(1'b0, 8'(a * 4), 8'h00);
            chk("reset value", 32'h0, q);
        end
        wb(1'b0, uibg_pkg::ADDR_STATUS, 8'h00);
        chk("status", 32'h01, q);
    endtask : s_reset
    task automatic s_regs;
        wb(1'b1, uibg_pkg::ADDR_IRQ_ENABLE, 8'hFF);
        wb(1'b0, uibg_pkg::ADDR_IRQ_ENABLE, 8'h00);
        chk("irq_enable", 32'h0F, q);
        wb(1'b1, uibg_pkg::ADDR_SCRATCH, 8'hA5);
        wb(1'b0, uibg_pkg::ADDR_SCRATCH, 8'h00);
        chk("scratch", 32'hA5, q);
        wb(1'b1, uibg_pkg::ADDR_DIV_LOW, 8'h5A);
        wb(1'b1, uibg_pkg::ADDR_DIV_HIGH, 8'hC3);
        wb(1'b0, uibg_pkg::ADDR_DIV_LOW, 8'h00);
        chk("divisor low", 32'h5A, q);
        wb(1'b0, uibg_pkg::ADDR_DIV_HIGH, 8'h00);
        chk("divisor high", 32'hC3, q);
        wb(1'b1, 8'h20, 8'h77);
        wb(1'b0, 8'h20, 8'h00);
        chk("unmapped", 32'h0, q);
        wb(1'b1, uibg_pkg::ADDR_STATUS, 8'hFF);
        wb(1'b0, uibg_pkg::ADDR_STATUS, 8'h00);
        chk("status", 32'h01, q);
    endtask : s_regs
    // rows: sources {modem,line,tx,rx,timeout}, enables, expected ident
    task automatic s_irq;
        logic [4:0] st[10] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h03,
                               5'h1E, 5'h1E, 5'h1E, 5'h1E, 5'h1E};
        logic [3:0] et[10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1,
                               4'hF, 4'hB, 4'hA, 4'h8, 4'h0};
        logic [3:0] it[10] = '{4'h4, 4'h2, 4'h6, 4'h0, 4'hC,
                               4'h6, 4'h4, 4'h2, 4'h0, 4'h1};
        wb(1'b1, uibg_pkg::ADDR_MODEM_CTRL, 8'h08);
        for (int r = 0; r < 10; r++) begin
            peer.set_src(st[r]);
            wb(1'b1, uibg_pkg::ADDR_IRQ_ENABLE, {4'h0, et[r]});
            repeat (2) @(posedge core_clk);
            #1;
            chk("uart_irq", {31'h0, it[r] != 4'h1}, {31'h0, uart_irq});
            chk("irq_ident", {28'h0, it[r]}, {28'h0, irq_ident});
        end
        wb(1'b1, uibg_pkg::ADDR_IRQ_ENABLE, 8'h0F);
        wb(1'b1, uibg_pkg::ADDR_MODEM_CTRL, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        chk("uart_irq", 32'h0, {31'h0, uart_irq});
        chk("irq_ident", 32'h6, {28'h0, irq_ident});
        peer.set_src(5'h00);
    endtask : s_irq
    task automatic baud(input logic [7:0] pre, input logic [7:0] spd,
                        input logic [15:0] div, input int cyc, input int e);
        // zero parks the counter so a large old count cannot linger
        wb(1'b1, uibg_pkg::ADDR_DIV_LOW, 8'h00);
        wb(1'b1, uibg_pkg::ADDR_DIV_HIGH, 8'h00);
        wb(1'b1, uibg_pkg::ADDR_PRESCALE_CFG, pre);
        wb(1'b1, uibg_pkg::ADDR_SPEED_CFG, spd);
        wb(1'b1, uibg_pkg::ADDR_DIV_LOW, div[7:0]);
        wb(1'b1, uibg_pkg::ADDR_DIV_HIGH, div[15:8]);
        // the emptied counter loads the new divisor at the next prescaler tick; settle first
        repeat (600) @(posedge core_clk);
        peer.clear_ticks();
        repeat (cyc) @(posedge core_clk);
        chk_near("tick16 count", e, peer.ticks);
    endtask : baud
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        s_reset();
        s_regs();
        s_irq();
        baud(8'h02, 8'h00, 16'h0001, 500, 240);
        baud(8'h01, 8'h00, 16'h0003, 1300, 128);
        baud(8'h00, 8'h00, 16'h0002, 2600, 48);
        baud(8'h03, 8'h00, 16'h0002, 2600, 48);
        baud(8'h00, 8'hC0, 16'h0004, 1000, 120);
        baud(8'h02, 8'h00, 16'h0100, 6400, 12);
        results();
    end
endmodule : uart_irq_enable_baud_gen_test

// ==== dv/uibg_checker.sv ====
// port assertions for the uart irq enable and baud block
`timescale 1ns/1ps
module uibg_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    // uart side
    input wire uibg_pkg::uibg_src_s irq_src,
    input wire logic uart_irq,
    input wire logic [3:0] irq_ident,
    input wire logic tick16
);
    logic [3:0] en_q;
    logic oe_q;
    logic take;
    logic [3:0] pend;
    logic irq_exp;
    logic [3:0] id_exp;
    // shadows follow the taking edge, as the registers do
    assign take = wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_q <= 4'h0;
        end else if (take && wb_adr == uibg_pkg::ADDR_IRQ_ENABLE) begin
            en_q <= wb_dat_w[3:0];
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oe_q <= 1'b0;
        end else if (take && wb_adr == uibg_pkg::ADDR_MODEM_CTRL) begin
            oe_q <= wb_dat_w[3];
        end
    end
    assign pend = en_q & {irq_src.modem_change, irq_src.line_status,
                          irq_src.tx_empty, irq_src.rx_ready};
    assign irq_exp = oe_q && (pend != 4'h0);
    assign id_exp = pend[2] ? uibg_pkg::IDENT_LINE :
                    pend[0] ? (irq_src.rx_timeout ? uibg_pkg::IDENT_TIMEOUT
                                                  : uibg_pkg::IDENT_RX) :
                    pend[1] ? uibg_pkg::IDENT_TX :
                    pend[3] ? uibg_pkg::IDENT_MODEM : uibg_pkg::IDENT_NONE;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    chk_ien_upper: assert property (
        wb_ack && !wb_we && wb_adr == uibg_pkg::ADDR_IRQ_ENABLE
        |-> wb_dat_r[31:4] == 28'h0) else $error("enable upper bits set");
    chk_wr_zero: assert property (wb_ack && wb_we |-> wb_dat_r == 32'h0)
        else $error("write returned data");
    chk_irq_gate: assert property (1'b1 |=> uart_irq == $past(irq_exp))
        else $error("irq output wrong");
    chk_ident_prio: assert property (1'b1 |=> irq_ident == $past(id_exp))
        else $error("ident wrong");
    chk_none_quiet: assert property (
        irq_ident == uibg_pkg::IDENT_NONE |-> !uart_irq)
        else $error("irq without source");
    chk_tick_pulse: assert property (tick16 |=> !tick16)
        else $error("tick wider than a cycle");
    cover property (uart_irq);
    cover property (tick16);
    cover property (wb_ack && wb_adr == uibg_pkg::ADDR_IRQ_ENABLE);
endmodule : uibg_checker

bind uibg_top uibg_checker chk_i (.core_clk(core_clk), .rst(rst),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .irq_src(irq_src), .uart_irq(uart_irq),
    .irq_ident(irq_ident), .tick16(tick16));

// ==== dv/uibg_uart_stub.sv ====
// stand-in for the uart core: source levels out, 16x ticks counted
`timescale 1ns/1ps
module uibg_uart_stub (
    // clock
    input wire logic core_clk,
    // uart side
    input wire logic tick16,
    output uibg_pkg::uibg_src_s irq_src
);
    int ticks = 0;
    logic clr = 1'b0;
    initial irq_src = '0;
    // clearing goes through the counting process so the two never race
    always @(posedge core_clk) begin
        if (clr) begin
            ticks <= 0;
        end else if (tick16) begin
            ticks <= ticks + 1;
        end
    end
    task automatic set_src(input uibg_pkg::uibg_src_s v);
        @(posedge core_clk);
        irq_src <= v;
    endtask : set_src
    task automatic clear_ticks;
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask : clear_ticks
endmodule : uibg_uart_stub
